// [design/csb_defines.svh]
/*
 register map constants for the channel/setup configuration bank.
 assumes a six-bit register address from the command decoder outside.
*/
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH
`define CSB_AW             6
`define CSB_DW             24
`define CSB_ADDR_CONVMODE  6'h01
`define CSB_ADDR_INTERFACE_MODE_CONTROL    6'h02
`define CSB_ADDR_CHAN0     6'h10
`define CSB_ADDR_SETUP0    6'h20
`define CSB_ADDR_FILT0     6'h28
`define CSB_ADDR_OFFS0     6'h30
`define CSB_ADDR_GAIN_COEFFICIENT_0     6'h38
`define CSB_RST_CONVMODE   16'h2000
`define CSB_RST_INTERFACE_MODE_CONTROL     16'h0000
`define CSB_RST_CHAN0      16'h8001
`define CSB_RST_CHANN      16'h0001
`define CSB_RST_SETUP      16'h1000
`define CSB_RST_FILT       16'h0500
`define CSB_RST_OFFS       24'h800000
`define CSB_RST_GAIN       24'h555550
`define CSB_MASK_CHAN      16'hf3ff
`define CSB_MASK_SETUP     16'h1f30
`define CSB_MASK_FILT      16'h9f7f
`define CSB_MASK_CONVMODE  16'ha07c
`define CSB_MASK_INTERFACE_MODE_CONTROL    16'h1fe5
`define CSB_CH_EN_BIT      15
`define CSB_SEL_HI         14
`define CSB_SEL_LO         12
`define CSB_IN_HI          9
`define CSB_CODING_BIT     12
`define CSB_REFBUFP_BIT    11
`define CSB_REFBUFN_BIT    10
`define CSB_INBUF_HI       9
`define CSB_INBUF_LO       8
`define CSB_REFSEL_HI      5
`define CSB_REFSEL_LO      4
`define CSB_ORDER_HI       6
`define CSB_ORDER_LO       5
`define CSB_ODR_HI         4
`define CSB_MODE_HI        6
`define CSB_MODE_LO        4
`define CSB_CLKSEL_HI      3
`define CSB_CLKSEL_LO      2
`define CSB_REFEN_BIT      15
`define CSB_CONT_READ_BIT  7
`define CSB_DATASTAT_BIT   6
`define CSB_CRCEN_BIT      2
`define CSB_SHORT_WORD_BIT 0
`endif

// [design/csb_pkg.sv]
/*
 types for the channel/setup configuration bank.
 assumes csb_defines.svh is compiled with it.
*/
`default_nettype none
package csb_pkg;
    typedef enum logic [1:0] {
        CSB_IDLE = 2'b00,
        CSB_SCAN = 2'b01
    } csb_seq_t;
    typedef struct packed {
        logic [15:0][15:0] chan;
        logic [7:0][15:0]  setup;
        logic [7:0][15:0]  filt;
        logic [7:0][23:0]  offs;
        logic [7:0][23:0]  gain;
        logic [15:0]       convmode;
        logic [15:0]       interface_mode_control;
        logic [23:0]       rdata;
        logic              rvalid;
        logic [3:0]        cur;
        logic              cur_valid;
        csb_seq_t          seq;
        logic [2:0]        cur_setup;
        logic [9:0]        cur_input;
    } csb_state_t;
endpackage
`default_nettype wire

// [design/csb_bank.sv]
/*
 channel/setup configuration bank with channel sequencer.
 assumes the serial command decoder delivers the six-bit register
 address with one-cycle write and read strobes on the same clock.
*/
`timescale 1ns/1ps
`include "csb_defines.svh"
`default_nettype none
module csb_bank #(
    parameter logic [23:0] GAIN_RESET = `CSB_RST_GAIN // device-specific
) (
    input  wire logic        clock,       // 25 MHz clock
    input  wire logic        resetn,      // async reset, active low
    input  wire logic        clk_en,      // freezes all state when low
    input  wire logic [5:0]  reg_addr,    // register address field
    input  wire logic        wr_stb,      // one-cycle write strobe
    input  wire logic [23:0] wr_data,     // write data, low aligned
    input  wire logic        rd_stb,      // one-cycle read strobe
    input  wire logic        step,        // conversion done, advance
    output logic [23:0]      rd_data,     // read data, held
    output logic             rd_valid,    // read data pulse
    output logic [3:0]       active_chan, // channel being converted
    output logic             active_valid,// a channel is enabled
    output logic [2:0]       active_setup,// setup of active channel
    output logic [9:0]       active_input,// input pair of active chan
    output logic [15:0]      conv_mode,   // converter mode register
    output logic [15:0]      if_mode      // interface mode register
);
    csb_pkg::csb_state_t q, d;

    // next enabled channel after cur, wrapping round to cur itself last; 5'h10 = none
    // fixed sixteen-step search, so its depth never depends on data
    function automatic logic [4:0] next_en(input logic [15:0] en,
                                           input logic [3:0]  cur);
        logic [4:0] r;
        logic [3:0] idx;
        r = 5'h10;
        for (int k = 16; k >= 1; k--)
        begin
            idx = cur + 4'(k);
            if (en[idx])
                r = {1'b0, idx};
        end
        return r;
    endfunction

    logic [15:0] en_vec;
    logic [4:0]  nxt;
    logic        grp_hit;
    logic [2:0]  grp_idx;

    // gather the channel enable bits
    always_comb
    begin
        for (int c = 0; c < 16; c++)
            en_vec[c] = q.chan[c][`CSB_CH_EN_BIT];
    end

    // state update: register writes, reads and sequencer
    always_comb
    begin
        d = q;
        d.rvalid = 1'b0;
        grp_idx = reg_addr[2:0];
        grp_hit = 1'b0;
        if (wr_stb)
        begin
            // low fields stored as given, reserved bits forced to zero
            case (reg_addr)
                `CSB_ADDR_CONVMODE:
                    d.convmode = wr_data[15:0] & `CSB_MASK_CONVMODE;
                `CSB_ADDR_INTERFACE_MODE_CONTROL:
                    d.interface_mode_control = wr_data[15:0] & `CSB_MASK_INTERFACE_MODE_CONTROL;
                default:
                begin
                    if (reg_addr[5:4] == 2'b01)
                        d.chan[reg_addr[3:0]] =
                            wr_data[15:0] & `CSB_MASK_CHAN;
                    else if (reg_addr[5:4] == 2'b10)
                    begin
                        grp_hit = 1'b1;
                        if (!reg_addr[3])
                            d.setup[grp_idx] =
                                wr_data[15:0] & `CSB_MASK_SETUP;
                        else
                            d.filt[grp_idx] =
                                wr_data[15:0] & `CSB_MASK_FILT;
                    end
                    else if (reg_addr[5:4] == 2'b11)
                    begin
                        if (!reg_addr[3])
                            d.offs[grp_idx] = wr_data;
                        else
                            d.gain[grp_idx] = wr_data;
                    end
                end
            endcase
        end
        if (rd_stb)
        begin
            d.rvalid = 1'b1;
            // unmapped addresses read as zero
            // reads look at q, so a same-cycle write shows next time
            case (reg_addr[5:4])
                2'b00:
                    d.rdata = (reg_addr == `CSB_ADDR_CONVMODE)
                        ? {8'h00, q.convmode}
                        : (reg_addr == `CSB_ADDR_INTERFACE_MODE_CONTROL)
                        ? {8'h00, q.interface_mode_control} : 24'h000000;
                2'b01: d.rdata = {8'h00, q.chan[reg_addr[3:0]]};
                2'b10: d.rdata = reg_addr[3] ? {8'h00, q.filt[grp_idx]}
                                             : {8'h00, q.setup[grp_idx]};
                default: d.rdata = reg_addr[3] ? q.gain[grp_idx]
                                               : q.offs[grp_idx];
            endcase
        end
        // sequencer: hop to next enabled channel on each step
        // a disabled current channel is left without waiting for a
        // step, so a channel switched off gets no further conversion
        nxt = next_en(en_vec, q.cur);
        case (q.seq)
            csb_pkg::CSB_IDLE:
            begin
                if (!nxt[4])
                begin
                    d.cur = nxt[3:0];
                    d.seq = csb_pkg::CSB_SCAN;
                end
            end
            csb_pkg::CSB_SCAN:
            begin
                if (nxt[4])
                    d.seq = csb_pkg::CSB_IDLE;
                else if (!en_vec[q.cur] || step)
                    d.cur = nxt[3:0];
            end
            default: d.seq = csb_pkg::CSB_IDLE;
        endcase
        d.cur_valid = (d.seq == csb_pkg::CSB_SCAN);
        // any channel may select any setup and input pair
        d.cur_setup = q.chan[d.cur][`CSB_SEL_HI:`CSB_SEL_LO];
        d.cur_input = q.chan[d.cur][`CSB_IN_HI:0];
        if (grp_hit)
            d.cur_setup = d.cur_setup; // group writes take effect next
    end

    // state register with reset values and clock enable
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int c = 0; c < 16; c++)
                q.chan[c] <= (c == 0) ? `CSB_RST_CHAN0
                                      : `CSB_RST_CHANN;
            for (int s = 0; s < 8; s++)
            begin
                q.setup[s] <= `CSB_RST_SETUP;
                q.filt[s]  <= `CSB_RST_FILT;
                q.offs[s]  <= `CSB_RST_OFFS;
                q.gain[s]  <= GAIN_RESET;
            end
            q.convmode  <= `CSB_RST_CONVMODE;
            q.interface_mode_control    <= `CSB_RST_INTERFACE_MODE_CONTROL;
            q.rdata     <= 24'h000000;
            q.rvalid    <= 1'b0;
            q.cur       <= 4'h0;
            q.cur_valid <= 1'b0;
            q.seq       <= csb_pkg::CSB_IDLE;
            q.cur_setup <= 3'h0;
            q.cur_input <= 10'h000;
        end
        else if (clk_en)
            q <= d;
    end

    // outputs straight from the state flops
    assign rd_data      = q.rdata;
    assign rd_valid     = q.rvalid;
    assign active_chan  = q.cur;
    assign active_valid = q.cur_valid;
    assign active_setup = q.cur_setup;
    assign active_input = q.cur_input;
    assign conv_mode    = q.convmode;
    assign if_mode      = q.interface_mode_control;

    // per-setup fields split out for the converter core; each setup
    // drives its own buffers, so no field is shared between setups
    wire [7:0]      coding_bits;  // 1 = bipolar coding
    wire [7:0]      refbuf_p;     // positive reference buffer on
    wire [7:0]      refbuf_n;     // negative reference buffer on
    wire [7:0]      inbuf_any;    // either input buffer on
    wire [7:0][1:0] ref_src;      // reference source choice
    wire [7:0][1:0] filt_order;   // filter order choice
    wire [7:0][4:0] filt_rate;    // output rate code
    genvar gs;
    generate
        for (gs = 0; gs < 8; gs++)
        begin : g_setup
            assign coding_bits[gs] = q.setup[gs][`CSB_CODING_BIT];
            assign refbuf_p[gs]    = q.setup[gs][`CSB_REFBUFP_BIT];
            assign refbuf_n[gs]    = q.setup[gs][`CSB_REFBUFN_BIT];
            assign inbuf_any[gs]   =
                |q.setup[gs][`CSB_INBUF_HI:`CSB_INBUF_LO];
            assign ref_src[gs]     =
                q.setup[gs][`CSB_REFSEL_HI:`CSB_REFSEL_LO];
            assign filt_order[gs]  =
                q.filt[gs][`CSB_ORDER_HI:`CSB_ORDER_LO];
            assign filt_rate[gs]   = q.filt[gs][`CSB_ODR_HI:0];
        end
    endgenerate

    // converter mode fields; the reference source choice stays per setup
    wire [2:0] conv_op    = q.convmode[`CSB_MODE_HI:`CSB_MODE_LO];
    wire [1:0] clock_src  = q.convmode[`CSB_CLKSEL_HI:`CSB_CLKSEL_LO];
    wire       ref_int_en = q.convmode[`CSB_REFEN_BIT];

    // interface mode fields handed on to the serial side
    wire continuous_read_enable = q.interface_mode_control[`CSB_CONT_READ_BIT];
    wire data_stat_en           = q.interface_mode_control[`CSB_DATASTAT_BIT];
    wire crc_en                 = q.interface_mode_control[`CSB_CRCEN_BIT];
    wire short_word_length      = q.interface_mode_control[`CSB_SHORT_WORD_BIT];

    // reset values: seen at the first edge after release, while the
    // flops still hold what the reset branch loaded
    a_ch0_reset: assert property (@(posedge clock)
        $rose(resetn) |-> q.chan[0] == `CSB_RST_CHAN0)
        else $error("channel 0 reset value wrong");
    a_mode_reset: assert property (@(posedge clock)
        $rose(resetn) |-> conv_mode == `CSB_RST_CONVMODE
        && if_mode == `CSB_RST_INTERFACE_MODE_CONTROL && q.filt[0] == `CSB_RST_FILT)
        else $error("mode reset wrong");
    a_coding_reset: assert property (@(posedge clock)
        $rose(resetn) |-> coding_bits == 8'hff)
        else $error("setup coding reset wrong");
    a_offs_reset: assert property (@(posedge clock)
        $rose(resetn) |-> q.offs[7] == `CSB_RST_OFFS)
        else $error("offset reset wrong");
    a_gain_digit: assert property (@(posedge clock)
        $rose(resetn) |-> q.gain[7][23:20] == 4'h5)
        else $error("gain reset leading digit wrong");
    a_field_reset: assert property (@(posedge clock)
        $rose(resetn) |-> inbuf_any == 8'h00 && refbuf_p == 8'h00
        && refbuf_n == 8'h00 && ref_src == 16'h0000
        && filt_order == 16'h0000 && filt_rate == 40'h0000000000)
        else $error("setup field reset wrong");
    a_mode_fields: assert property (@(posedge clock)
        $rose(resetn) |-> conv_op == 3'h0 && clock_src == 2'h0
        && !ref_int_en && !continuous_read_enable && !data_stat_en
        && !crc_en && !short_word_length)
        else $error("mode field reset wrong");

    // writes: the masked word lands one cycle after the strobe; a read
    // in the same cycle does not disturb it
    a_offs_write: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && wr_stb && reg_addr[5:3] == 3'b110
        |=> q.offs[$past(reg_addr[2:0])] == $past(wr_data))
        else $error("offset write lost");
    a_gain_write: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && wr_stb && reg_addr[5:3] == 3'b111
        |=> q.gain[$past(reg_addr[2:0])] == $past(wr_data))
        else $error("gain write lost");
    a_chan_write: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && wr_stb && reg_addr[5:4] == 2'b01
        |=> q.chan[$past(reg_addr[3:0])]
            == ($past(wr_data[15:0]) & `CSB_MASK_CHAN))
        else $error("channel write lost");
    a_setup_write: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && wr_stb && reg_addr[5:3] == 3'b100
        |=> q.setup[$past(reg_addr[2:0])]
            == ($past(wr_data[15:0]) & `CSB_MASK_SETUP))
        else $error("setup write lost");
    a_filt_write: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && wr_stb && reg_addr[5:3] == 3'b101
        |=> q.filt[$past(reg_addr[2:0])]
            == ($past(wr_data[15:0]) & `CSB_MASK_FILT))
        else $error("filter write lost");
    a_convmode_write: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && wr_stb && reg_addr == `CSB_ADDR_CONVMODE
        |=> conv_mode == ($past(wr_data[15:0]) & `CSB_MASK_CONVMODE))
        else $error("mode write lost");
    a_interface_mode_control_write: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && wr_stb && reg_addr == `CSB_ADDR_INTERFACE_MODE_CONTROL
        |=> if_mode == ($past(wr_data[15:0]) & `CSB_MASK_INTERFACE_MODE_CONTROL))
        else $error("interface mode write lost");

    // reads: valid for one cycle; the data is the word from before any
    // same-cycle write
    a_chan_read: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && rd_stb && reg_addr[5:4] == 2'b01
        |=> rd_valid && rd_data == {8'h00, $past(q.chan[reg_addr[3:0]])})
        else $error("channel read wrong");
    a_unmapped_read: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && rd_stb && reg_addr[5:4] == 2'b00
        && reg_addr != `CSB_ADDR_CONVMODE && reg_addr != `CSB_ADDR_INTERFACE_MODE_CONTROL
        |=> rd_valid && rd_data == 24'h000000)
        else $error("unmapped read not zero");
    a_rd_pulse: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && !rd_stb |=> !rd_valid)
        else $error("read valid held too long");

    // sequencer: a disabled current channel is left at once, a step
    // hops to the next enabled one
    a_seq_enabled: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && active_valid && !en_vec[active_chan]
        |=> !active_valid || active_chan != $past(active_chan))
        else $error("sequencer stayed on disabled channel");
    a_seq_step: assert property (
        @(posedge clock) disable iff (!resetn)
        clk_en && q.seq == csb_pkg::CSB_SCAN && step && !nxt[4]
        |=> active_chan == $past(nxt[3:0]))
        else $error("sequencer skipped wrong");
    a_setup_mask: assert property (
        @(posedge clock) disable iff (!resetn)
        (q.setup[0] & ~`CSB_MASK_SETUP) == 16'h0000)
        else $error("setup reserved bits set");

    // clock enable low must leave every flop untouched
    a_freeze_hold: assert property (
        @(posedge clock) disable iff (!resetn)
        !clk_en |=> $stable(q))
        else $error("state moved while frozen");

    // main scenarios: wrap-around, coefficient write, idle bank, a skip
    // over a disabled current channel, and an input buffer in use
    c_scan_wrap: cover property (@(posedge clock)
        active_valid && active_chan == 4'hf ##1 active_chan == 4'h0);
    c_gain_wr: cover property (@(posedge clock)
        wr_stb && reg_addr[5:3] == 3'b111);
    c_idle: cover property (@(posedge clock) resetn && !active_valid);
    c_skip_off: cover property (@(posedge clock)
        active_valid && !en_vec[active_chan] && !step);
    c_inbuf_on: cover property (@(posedge clock) inbuf_any != 8'h00);
endmodule // csb_bank
`default_nettype wire

// [bench/tb.sv]
/*
 self-checking bench for the channel/setup configuration bank.
 assumes csb_defines.svh and csb_pkg.sv are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [5:0]  a;
        logic        w;
        logic [23:0] d;
        logic [23:0] e;
    } csb_row_t;
    localparam logic [23:0] GAIN_RST = 24'h5abcd0; // leading five kept
    logic        clock, resetn, clk_en, wr_stb, rd_stb, step;
    logic [5:0]  reg_addr;
    logic [23:0] wr_data, rd_data;
    logic        rd_valid, active_valid;
    logic [3:0]  active_chan;
    logic [2:0]  active_setup;
    logic [9:0]  active_input;
    logic [15:0] conv_mode, if_mode;
    int          err_total, n_checks;
    csb_row_t    rows [22];

    csb_bank #(.GAIN_RESET(GAIN_RST)) u_dut (
        .clock(clock), .resetn(resetn), .clk_en(clk_en),
        .reg_addr(reg_addr), .wr_stb(wr_stb), .wr_data(wr_data),
        .rd_stb(rd_stb), .step(step), .rd_data(rd_data),
        .rd_valid(rd_valid), .active_chan(active_chan),
        .active_valid(active_valid), .active_setup(active_setup),
        .active_input(active_input), .conv_mode(conv_mode),
        .if_mode(if_mode)
    );

    // 40 ns clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input string n, input logic [23:0] s,
                       input logic [23:0] e);
        n_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // strobes held for exactly one rising edge, read data looked at after
    task automatic acc(input logic [5:0] a, input logic w, input logic r,
                       input logic [23:0] d);
        @(negedge clock);
        reg_addr = a;
        wr_stb = w;
        rd_stb = r;
        wr_data = d;
        @(negedge clock);
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        if (r) chk("rd_valid", {23'h0, rd_valid}, 24'h1);
    endtask

    task automatic rd(input logic [5:0] a, input logic [23:0] e);
        acc(a, 1'b0, 1'b1, 24'h0);
        chk("rd_data", rd_data, e);
    endtask

    // one step pulse, then one spare cycle; setup/input follow the channel on the same edge
    task automatic adv(input logic [3:0] c);
        @(negedge clock);
        step = 1'b1;
        @(negedge clock);
        step = 1'b0;
        @(negedge clock);
        chk("active_chan", {20'h0, active_chan}, {20'h0, c});
    endtask

    task automatic reset_dut;
        resetn = 1'b0;
        repeat (3) @(negedge clock);
        chk("conv_mode", {8'h0, conv_mode}, 24'h002000);
        chk("if_mode", {8'h0, if_mode}, 24'h000000);
        chk("rst_valid", {23'h0, rd_valid}, 24'h0);
        resetn = 1'b1;
        repeat (2) @(negedge clock);
    endtask

    // watchdog far beyond the roughly 110 cycles the tests need
    initial
    begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        err_total = 0;
        n_checks = 0;
        clk_en = 1'b1;
        reg_addr = 6'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        wr_data = 24'h0;
        step = 1'b0;
        resetn = 1'b0;
        rows = '{
            '{6'h01, 1'b0, 24'h0, 24'h002000},
            '{6'h02, 1'b0, 24'h0, 24'h0},
            '{6'h10, 1'b0, 24'h0, 24'h008001},
            '{6'h1f, 1'b0, 24'h0, 24'h1},
            '{6'h20, 1'b0, 24'h0, 24'h001000},
            '{6'h27, 1'b0, 24'h0, 24'h1000},
            '{6'h28, 1'b0, 24'h0, 24'h000500},
            '{6'h2f, 1'b0, 24'h0, 24'h0500},
            '{6'h30, 1'b0, 24'h0, 24'h800000},
            '{6'h37, 1'b0, 24'h0, 24'h800000},
            '{6'h38, 1'b0, 24'h0, GAIN_RST},
            '{6'h3f, 1'b0, 24'h0, GAIN_RST},
            '{6'h00, 1'b0, 24'h0, 24'h0},
            '{6'h11, 1'b1, 24'h7fff, 24'h73ff},
            '{6'h21, 1'b1, 24'hffff, 24'h1f30},
            '{6'h2e, 1'b1, 24'hffff, 24'h9f7f},
            '{6'h01, 1'b1, 24'hffff, 24'ha07c},
            '{6'h02, 1'b1, 24'hffff, 24'h1fe5},
            '{6'h3f, 1'b1, 24'h123456, 24'h123456},
            '{6'h3e, 1'b0, 24'h0, GAIN_RST},
            '{6'h35, 1'b1, 24'habcdef, 24'habcdef},
            '{6'h03, 1'b1, 24'hffff, 24'h0}
        };
        reset_dut();
        chk("seq_ch", {20'h0, active_chan}, 24'h0);
        chk("seq_in", {14'h0, active_input}, 24'h1);
        $display("test reset done");
        // register table: reset values, masks, neighbours untouched
        foreach (rows[i])
        begin
            if (rows[i].w) acc(rows[i].a, 1'b1, 1'b0, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk("conv_out", {8'h0, conv_mode}, 24'h00a07c);
        chk("if_out", {8'h0, if_mode}, 24'h001fe5);
        $display("test register rows done");
        // frozen clock enable drops a write
        clk_en = 1'b0;
        acc(6'h12, 1'b1, 1'b0, 24'h8005);
        clk_en = 1'b1;
        rd(6'h12, 24'h0001);
        // same-cycle write and read returns the old word
        acc(6'h12, 1'b1, 1'b1, 24'h0007);
        chk("wr_rd_old", rd_data, 24'h0001);
        rd(6'h12, 24'h0007);
        $display("test strobes done");
        // ch3 on setup 5, ch15 on setup 7, any input pair
        acc(6'h13, 1'b1, 1'b0, 24'hd02a);
        acc(6'h1f, 1'b1, 1'b0, 24'hf3ff);
        adv(4'h3);
        chk("setup3", {21'h0, active_setup}, 24'h5);
        chk("input3", {14'h0, active_input}, 24'h02a);
        adv(4'hf);
        chk("setup15", {21'h0, active_setup}, 24'h7);
        adv(4'h0);
        // disabling the current channel skips it without a step
        acc(6'h10, 1'b1, 1'b0, 24'h0001);
        repeat (3) @(negedge clock);
        chk("skip_ch", {20'h0, active_chan}, 24'h3);
        acc(6'h13, 1'b1, 1'b0, 24'h0);
        acc(6'h1f, 1'b1, 1'b0, 24'h0);
        repeat (3) @(negedge clock);
        chk("none_valid", {23'h0, active_valid}, 24'h0);
        $display("test sequencer done");
        // second reset in mid-run restores the bank
        reset_dut();
        rd(6'h11, 24'h0001);
        rd(6'h3f, GAIN_RST);
        rd(6'h35, 24'h800000);
        chk("seq_valid", {23'h0, active_valid}, 24'h1);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
